// file: hdl/aac_config.sv
// Function
// - control bit 6 set selects external reference pair, clear selects bandgap.
// - unipolar bit set: zero input gives all-zero 24-bit result.
// - unipolar bit clear: zero input gives result with only msb set.
// - input field decodes singles, differential pairs, temperature sensor, common short.
// - temperature sensor at zero degrees returns mid-scale code with unipolar bit clear.
// - each degree rise adds one lsb to the result high byte with unipolar bit clear.
// - filter word sets decimation, resets to 69 decimal.
// - word rate is modulator rate over 24 x word chopped, 8 x word otherwise.
// - chop-disable mode bit zero means chopping active; rate follows it.
// - chopping on and word below 13 uses 13 instead.
// - calibration uses the programmed filter word, never forced to maximum.
module aac_config #(
   parameter int DECIM_W = 8,
   parameter int RESULT_W = 24
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // special function register port
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   output logic sfr_rdata_valid,
   // converter mode and calibration
   input wire logic chop_disable,
   input wire logic cal_active,
   // modulator side
   input wire logic mod_tick,
   input wire logic [RESULT_W-1:0] mod_data,
   input wire logic [7:0] temp_degrees,
   // analog configuration
   output aac_pkg::aac_analog_cfg_t analog_cfg,
   output logic [DECIM_W-1:0] decimation_value,
   output logic chop_on,
   // results
   output logic [RESULT_W-1:0] aux_result,
   output logic [7:0] aux_result_high_byte,
   output logic result_strobe,
   output logic result_settled
);
   import aac_pkg::*;

   if (DECIM_W != 8) begin : g_bad_decim
      $error("aac_config: filter word must be 8 bits");
   end
   if (RESULT_W != AAC_RESULT_W) begin : g_bad_result
      $error("aac_config: result must be 24 bits");
   end

   logic [7:0] control_reg, control_next;
   logic [DECIM_W-1:0] decim_reg, decim_next;
   logic [7:0] rdata_reg, rdata_next;
   logic rvalid_reg, rvalid_next;
   logic [RESULT_W-1:0] result_reg, result_next;
   logic settled_reg, settled_next;
   logic strobe_reg, strobe_next;
   logic [1:0] settle_reg, settle_next;
   logic chop_reg, chop_next;
   logic [DECIM_W-1:0] decim_eff;
   logic conv_strobe;
   logic cfg_change;
   aac_mux_t mux;
   logic [3:0] sel;
   logic signed [RESULT_W-1:0] raw;
   logic [RESULT_W-1:0] coded;

   // register writes and reads
   always_comb begin
      control_next = control_reg;
      decim_next = decim_reg;
      rdata_next = rdata_reg;
      rvalid_next = 1'b0;
      if (sfr_wr) begin
         if (sfr_addr == AAC_ADDR_CONTROL) begin
            control_next = sfr_wdata & AAC_CONTROL_MASK;
         end else if (sfr_addr == AAC_ADDR_DECIM) begin
            decim_next = sfr_wdata;
         end
      end
      if (sfr_rd) begin
         rvalid_next = 1'b1;
         case (sfr_addr)
            AAC_ADDR_CONTROL: rdata_next = control_reg & AAC_CONTROL_MASK;
            AAC_ADDR_DECIM: rdata_next = decim_reg;
            default: rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         control_reg <= AAC_CONTROL_RST;
         decim_reg <= AAC_DECIM_RST;
         rdata_reg <= 8'h00;
         rvalid_reg <= 1'b0;
      end else begin
         control_reg <= control_next;
         decim_reg <= decim_next;
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   assign sfr_rdata = rdata_reg;
   assign sfr_rdata_valid = rvalid_reg;

   // chop follows the mode bit; calibration leaves the word alone
   always_comb begin
      chop_next = ~chop_disable;
      decim_eff = decim_reg;
      if (chop_reg && decim_reg < AAC_DECIM_MIN_CHOP) begin
         decim_eff = AAC_DECIM_MIN_CHOP;
      end
   end

   // input multiplexer decode
   always_comb begin
      sel = control_reg[AAC_INPUT_LSB +: AAC_INPUT_W];
      mux = '0;
      if (sel <= AAC_SEL_LAST_SINGLE) begin
         mux.pos_input = sel;
         mux.neg_is_common = 1'b1;
      end else if (sel < AAC_SEL_TEMP) begin
         mux.pos_input = 4'((sel - AAC_SEL_FIRST_DIFF) << 1);
         mux.neg_input = 4'(((sel - AAC_SEL_FIRST_DIFF) << 1) + 4'h1);
      end else if (sel == AAC_SEL_TEMP) begin
         mux.temp_sensor = 1'b1;
      end else begin
         mux.short_common = 1'b1;
         mux.neg_is_common = 1'b1;
      end
   end

   always_comb begin
      analog_cfg.ext_reference = control_reg[AAC_EXT_REF_BIT];
      analog_cfg.unipolar = control_reg[AAC_UNIPOLAR_BIT];
      analog_cfg.mux = mux;
   end

   // a rewrite of either register or a chop flip restarts the period
   assign cfg_change = (sfr_wr && (sfr_addr == AAC_ADDR_CONTROL || sfr_addr == AAC_ADDR_DECIM))
      || (chop_reg != chop_next);

   aac_rate_timer #(
      .DECIM_W(DECIM_W)
   ) u_rate (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .mod_tick(mod_tick),
      .restart(cfg_change),
      .chop_on(chop_reg),
      .decimation_value(decim_eff),
      .conv_strobe(conv_strobe)
   );

   // sensor is trimmed so zero degrees sits at mid-scale and degrees land in the high byte with unipolar bit clear
   always_comb begin
      if (mux.temp_sensor) begin
         raw = signed'({temp_degrees, 16'h0000});
      end else begin
         raw = signed'(mod_data);
      end
      if (analog_cfg.unipolar) begin
         // negative inputs clip at zero in unipolar mode
         coded = raw[RESULT_W-1] ? AAC_ZERO_SCALE : {raw[RESULT_W-2:0], 1'b0};
      end else begin
         coded = raw ^ AAC_MID_SCALE;
      end
   end

   // settle counting: early outputs are still flagged unsettled
   always_comb begin
      result_next = result_reg;
      strobe_next = 1'b0;
      settled_next = settled_reg;
      settle_next = settle_reg;
      if (cfg_change) begin
         settle_next = chop_next ? AAC_SETTLE_CHOP : AAC_SETTLE_NOCHOP;
         settled_next = 1'b0;
      end else if (conv_strobe) begin
         result_next = coded;
         strobe_next = 1'b1;
         if (settle_reg <= 2'h1) begin
            settle_next = 2'h0;
            settled_next = 1'b1;
         end else begin
            settle_next = settle_reg - 2'h1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         result_reg <= '0;
         strobe_reg <= 1'b0;
         settled_reg <= 1'b0;
         settle_reg <= AAC_SETTLE_CHOP;
         chop_reg <= 1'b1;
      end else begin
         result_reg <= result_next;
         strobe_reg <= strobe_next;
         settled_reg <= settled_next;
         settle_reg <= settle_next;
         chop_reg <= chop_next;
      end
   end

   assign aux_result = result_reg;
   assign aux_result_high_byte = result_reg[RESULT_W-1 -: 8];
   assign result_strobe = strobe_reg;
   assign result_settled = settled_reg;
   assign decimation_value = decim_eff;
   assign chop_on = chop_reg;
endmodule : aac_config

// file: hdl/aac_pkg.sv
package aac_pkg;
   // special function register addresses
   localparam logic [7:0] AAC_ADDR_CONTROL = 8'hd3;
   localparam logic [7:0] AAC_ADDR_DECIM = 8'hd4;
   // reset values
   localparam logic [7:0] AAC_CONTROL_RST = 8'h00;
   localparam logic [7:0] AAC_DECIM_RST = 8'h45;
   // control field positions
   localparam int AAC_EXT_REF_BIT = 6;
   localparam int AAC_UNIPOLAR_BIT = 5;
   localparam int AAC_INPUT_LSB = 0;
   localparam int AAC_INPUT_W = 4;
   localparam logic [7:0] AAC_CONTROL_MASK = 8'h6f;
   // input select codes
   localparam logic [3:0] AAC_SEL_LAST_SINGLE = 4'h9;
   localparam logic [3:0] AAC_SEL_FIRST_DIFF = 4'ha;
   localparam logic [3:0] AAC_SEL_TEMP = 4'he;
   localparam logic [3:0] AAC_SEL_SHORT = 4'hf;
   // filter and rate figures
   localparam logic [7:0] AAC_DECIM_MIN_CHOP = 8'h0d;
   localparam logic [7:0] AAC_DECIM_MAX = 8'hff;
   localparam int AAC_MOD_FREQ_HZ = 32768;
   localparam int AAC_RATE_BASE = 8;
   localparam int AAC_CHOP_FACTOR = 3;
   localparam logic [1:0] AAC_SETTLE_CHOP = 2'h2;
   localparam logic [1:0] AAC_SETTLE_NOCHOP = 2'h3;
   // result coding
   localparam int AAC_RESULT_W = 24;
   localparam logic [23:0] AAC_MID_SCALE = 24'h800000;
   localparam logic [23:0] AAC_ZERO_SCALE = 24'h000000;

   typedef struct packed {
      logic [3:0] pos_input;
      logic [3:0] neg_input;
      logic neg_is_common;
      logic temp_sensor;
      logic short_common;
   } aac_mux_t;

   typedef struct packed {
      logic ext_reference;
      logic unipolar;
      aac_mux_t mux;
   } aac_analog_cfg_t;
endpackage : aac_pkg

// file: hdl/aac_rate_timer.sv
module aac_rate_timer #(
   parameter int DECIM_W = 8
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // modulator timing
   input wire logic mod_tick,
   input wire logic restart,
   input wire logic chop_on,
   input wire logic [DECIM_W-1:0] decimation_value,
   // conversion period end
   output logic conv_strobe
);
   import aac_pkg::*;

   localparam int CNT_W = DECIM_W + 5;

   // counter is five bits wider than the word, so 24 x word always fits; widths outside this range are rejected
   if (DECIM_W < 4 || DECIM_W > 16) begin : g_bad_width
      $error("aac_rate_timer: DECIM_W out of range");
   end

   logic [CNT_W-1:0] tick_reg, tick_next;
   logic strobe_reg, strobe_next;
   logic [CNT_W-1:0] period;

   // period in modulator ticks: 8 x word, times three with chopping
   always_comb begin
      period = CNT_W'(AAC_RATE_BASE) * CNT_W'(decimation_value);
      if (chop_on) begin
         period = CNT_W'(AAC_CHOP_FACTOR) * period;
      end
   end

   always_comb begin
      tick_next = tick_reg;
      strobe_next = 1'b0;
      if (restart) begin
         tick_next = '0;
      end else if (mod_tick) begin
         if (tick_reg + CNT_W'(1) >= period) begin
            tick_next = '0;
            strobe_next = 1'b1;
         end else begin
            tick_next = tick_reg + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         tick_reg <= '0;
         strobe_reg <= 1'b0;
      end else begin
         tick_reg <= tick_next;
         strobe_reg <= strobe_next;
      end
   end

   assign conv_strobe = strobe_reg;
endmodule : aac_rate_timer

// file: dv/aac_config_sva.sv
module aac_config_sva #(parameter int DECIM_W = 8, parameter int RESULT_W = 24) (
   // clock, reset and writes
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   // mode, sensor and outputs
   input wire logic chop_disable,
   input wire logic [7:0] temp_degrees,
   input wire aac_pkg::aac_analog_cfg_t analog_cfg,
   input wire logic [DECIM_W-1:0] decimation_value,
   input wire logic chop_on,
   input wire logic [RESULT_W-1:0] aux_result,
   input wire logic [7:0] aux_result_high_byte,
   input wire logic result_strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   import aac_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   a_ext_ref_follow: assert property (sfr_wr && sfr_addr == 8'hd3
      |=> analog_cfg.ext_reference == $past(sfr_wdata[6])) else $error("ext ref bit wrong");
   a_unipolar_follow: assert property (sfr_wr && sfr_addr == 8'hd3
      |=> analog_cfg.unipolar == $past(sfr_wdata[5])) else $error("unipolar bit wrong");
   a_temp_decode: assert property (sfr_wr && sfr_addr == 8'hd3
      |=> analog_cfg.mux.temp_sensor == ($past(sfr_wdata[3:0]) == 4'he)) else $error("temp decode wrong");
   a_short_decode: assert property (sfr_wr && sfr_addr == 8'hd3
      |=> analog_cfg.mux.short_common == ($past(sfr_wdata[3:0]) == 4'hf)) else $error("short decode wrong");
   a_min_word_chop: assert property (chop_on |-> decimation_value >= 8'h0d)
      else $error("word below floor");
   a_chop_follow: assert property (chop_disable [*2] |-> !chop_on)
      else $error("chop still on");
   a_temp_code: assert property (result_strobe && analog_cfg.mux.temp_sensor && !analog_cfg.unipolar
      |-> aux_result == {temp_degrees ^ 8'h80, 16'h0000}) else $error("temp code wrong");
   a_high_byte: assert property (result_strobe && analog_cfg.mux.temp_sensor && !analog_cfg.unipolar
      |-> aux_result_high_byte == 8'(temp_degrees + 8'h80)) else $error("high byte wrong");
endmodule : aac_config_sva
bind aac_config aac_config_sva #(.DECIM_W(DECIM_W), .RESULT_W(RESULT_W)) u_sva (.sys_clk, .sys_rst, .sfr_addr,
   .sfr_wr, .sfr_wdata, .chop_disable, .temp_degrees, .analog_cfg, .decimation_value, .chop_on, .aux_result,
   .aux_result_high_byte, .result_strobe);

// file: dv/aac_mod_model.sv
module aac_mod_model #(parameter logic [23:0] LEVEL = 24'h2a5a5a) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // setup in, modulator out
   input wire aac_pkg::aac_analog_cfg_t analog_cfg,
   output logic mod_tick,
   output logic [23:0] mod_data
);
   timeunit 1ns;
   timeprecision 1ps;
   import aac_pkg::*;
   logic [1:0] div_reg;
   // tick far faster than real so a conversion fits in about a thousand cycles
   always_ff @(posedge sys_clk) begin
      div_reg <= sys_rst ? 2'h0 : div_reg + 2'h1;
   end
   assign mod_tick = (div_reg == 2'h3);
   // shorted inputs give a zero differential
   assign mod_data = analog_cfg.mux.short_common ? 24'h000000 : LEVEL;
endmodule : aac_mod_model

// file: dv/test_aac_config.sv
module test_aac_config;
   timeunit 1ns;
   timeprecision 1ps;
   import aac_pkg::*;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic sfr_wr = 1'b0, sfr_rd = 1'b0, chop_disable = 1'b0, cal_active = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, temp_degrees = 8'h00;
   logic sfr_rdata_valid, chop_on, result_strobe, result_settled, mod_tick;
   logic [7:0] sfr_rdata, decimation_value, aux_result_high_byte;
   logic [23:0] mod_data, aux_result;
   aac_analog_cfg_t analog_cfg;
   int errors = 0, check_count = 0, ticks;
   always #2 sys_clk = ~sys_clk;
   aac_config u_dut (.sys_clk, .sys_rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_rdata_valid,
      .chop_disable, .cal_active, .mod_tick, .mod_data, .temp_degrees, .analog_cfg, .decimation_value, .chop_on,
      .aux_result, .aux_result_high_byte, .result_strobe, .result_settled);
   aac_mod_model u_mod (.sys_clk, .sys_rst, .analog_cfg, .mod_tick, .mod_data);
   task automatic finish_test;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input string what, input logic [23:0] exp, got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // one byte access; a read also checks the answer a cycle later
   task automatic bus(input logic rd_op, input logic [7:0] a, d);
      @(negedge sys_clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_rd = rd_op;
      sfr_wr = !rd_op;
      @(negedge sys_clk);
      {sfr_rd, sfr_wr} = 2'b00;
      if (rd_op) chk("rdata", {1'b1, d}, {sfr_rdata_valid, sfr_rdata});
   endtask : bus
   task automatic wait_strobe;
      ticks = 0;
      for (int i = 0; i < 4000; i++) begin
         @(negedge sys_clk);
         if (mod_tick === 1'b1) ticks++;
         if (result_strobe === 1'b1) return;
      end
      chk("strobe timeout", 24'h1, 24'h0);
      finish_test();
   endtask : wait_strobe
   task automatic t_regs;
      bus(1'b1, 8'hd3, 8'h00);
      bus(1'b1, 8'hd4, 8'h45);
      bus(1'b1, 8'hd5, 8'h00);
      bus(1'b0, 8'hd3, 8'hff);
      bus(1'b1, 8'hd3, 8'h6f);
      chk("ref and coding", 24'h3, {analog_cfg.ext_reference, analog_cfg.unipolar});
      bus(1'b0, 8'hd4, 8'h05);
      chk("decim chop", 24'h0d, decimation_value);
      chop_disable = 1'b1;
      repeat (2) @(negedge sys_clk);
      chk("decim nochop", 24'h05, decimation_value);
      bus(1'b0, 8'hd4, 8'hff);
      cal_active = 1'b1;
      chk("decim cal max", 24'hff, decimation_value);
      bus(1'b0, 8'hd4, 8'h52);
      chk("decim cal", 24'h52, decimation_value);
      cal_active = 1'b0;
      chop_disable = 1'b0;
   endtask : t_regs
   task automatic t_mux;
      logic [3:0] p;
      aac_mux_t m;
      for (int c = 0; c < 16; c++) begin
         p = (c < 10) ? c[3:0] : 4'((c - 10) * 2);
         bus(1'b0, 8'hd3, 8'(c));
         m = analog_cfg.mux;
         chk("temp short", {c == 14, c == 15}, {m.temp_sensor, m.short_common});
         if (c < 14) chk("pos common", {p, c < 10}, {m.pos_input, m.neg_is_common});
         if (c >= 10 && c < 14) chk("neg", p + 4'h1, m.neg_input);
      end
   endtask : t_mux
   task automatic t_conv;
      bus(1'b0, 8'hd4, 8'h0d);
      bus(1'b0, 8'hd3, 8'h0e);
      wait_strobe();
      wait_strobe();
      chk("ticks chop", 24'd312, ticks);
      chk("temp zero", 24'h800000, aux_result);
      chk("settled chop", 24'h1, result_settled);
      // change the sensor one cycle late so the strobe still sees the old reading
      @(negedge sys_clk);
      temp_degrees = 8'h05;
      wait_strobe();
      chk("temp high", 24'h85, aux_result_high_byte);
      chop_disable = 1'b1;
      bus(1'b0, 8'hd3, 8'h2f);
      repeat (2) wait_strobe();
      chk("ticks nochop", 24'd104, ticks);
      chk("settled early", 24'h0, result_settled);
      wait_strobe();
      chk("unipolar zero", 24'h000000, aux_result);
      chk("settled nochop", 24'h1, result_settled);
      // a plain channel carries the model level through offset coding
      bus(1'b0, 8'hd3, 8'h00);
      wait_strobe();
      chk("bipolar level", 24'(u_mod.LEVEL + AAC_MID_SCALE), aux_result);
   endtask : t_conv
   task automatic t_reset;
      bus(1'b0, 8'hd4, 8'h20);
      @(negedge sys_clk);
      sys_rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      sys_rst = 1'b0;
      chk("reset settled", 24'h0, {result_strobe, result_settled});
      bus(1'b1, 8'hd4, 8'h45);
      bus(1'b1, 8'hd3, 8'h00);
   endtask : t_reset
   initial begin
      repeat (5) @(negedge sys_clk);
      sys_rst = 1'b0;
      t_regs();
      t_mux();
      t_conv();
      t_reset();
      finish_test();
   end
endmodule : test_aac_config
